// >>> logic/srsei_top.sv
// Receiver status, interrupt causes and error substitution.
// Assumes channel-status, lock and sample inputs come from logic on mclk_i.
`timescale 1ns/1ps
`include "srsei_cfg.svh"

// Overview of operation
// (RULE1) Status bit 0 shows channel-status bit 1
// (RULE2) Status bit 1 shows burst sync detected
// (RULE3) Status bit 2 shows channel-status copy bit
// (RULE4) Status bit 3 shows pre-emphasis bit
// (RULE5) Status bits 5:4 hold recovered rate code
// (RULE6) Status bit 6 set while clock unlocked
// (RULE7) Host reads status after a change cause
// (RULE8) Suppress bits block cause and interrupt; reset zero
// (RULE9) Suppress bit order matches cause bit order
// (RULE10) Coding, parity or preamble error flags corrupt
// (RULE11) Validity bit set flags source invalid
// (RULE12) Unmasked error causes pass data unchanged
// (RULE13) Host handles errored data in manual mode
// (RULE14) Masked errors replace data: zeros or last
// (RULE15) Pass bit lets invalid samples through unchanged
// (RULE16) Transmitter path replaced only for invalid
// (RULE17) Sync pattern: four zeros, Pa, Pb
// (RULE18) Compressed payload is nonlinear OR sync
// (RULE19) Nonlinear or sync change raises payload cause
// (RULE20) Invalid and corrupt causes are level sensitive
// (RULE21) Refresh and rate causes set on transitions
// (RULE22) Causes held until cause register read
// (RULE23) Interrupt low while any cause bit set
module srsei_top (
   // Clock and reset
   input wire logic mclk_i,
   input wire logic rst_i,
   // Register port
   input wire logic [6:0] reg_addr_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   input wire logic [7:0] reg_wdata_i,
   output logic [7:0] reg_rdata_o,
   // Channel status and lock from the receiver
   input wire logic cs_nonlinear_i,
   input wire logic copy_permit_flag_i,
   input wire logic preemphasis_flag_i,
   input wire logic [1:0] recovered_rate_code_i,
   input wire logic unlock_i,
   input wire logic cs_refresh_flag_i,
   // Received subframe stream
   input wire logic [23:0] rx_sample_i,
   input wire logic rx_valid_i,
   output logic rx_ready_o,
   input wire logic rx_biphase_err_i,
   input wire logic rx_parity_err_i,
   input wire logic rx_preamble_err_i,
   input wire logic rx_validity_i,
   // Output stream to audio interface and transmitter
   output logic [23:0] aif_data_o,
   output logic [23:0] tx_data_o,
   output logic out_valid_o,
   input wire logic out_ready_i,
   // Indications
   output logic payload_compressed_o,
   output logic irq_n_o
);

   //----------
   // Storage
   //----------
   logic [7:0] rx_error_fill_config_q;
   logic [7:0] irq_suppress_reg_q;
   logic [7:0] irq_cause_reg_q;
   logic [7:0] irq_cause_reg_d;
   logic [7:0] rx_status_reg;
   logic [7:0] cause_event;

   logic nonlinear_q;
   logic copy_permit_flag_q;
   logic preemphasis_flag_q;
   logic [1:0] recovered_rate_code_q;
   logic unlock_q;

   logic cs_refresh_flag_q;
   logic burst_sync;
   logic burst_sync_q;

   logic rx_frame_corrupt_q;
   logic rx_invalid_q;

   logic payload_compressed_q;
   logic irq_n_q;
   logic [7:0] rdata_q;

   srsei_pkg::srsei_sample_type last_aif_q;
   srsei_pkg::srsei_sample_type last_tx_q;
   srsei_pkg::srsei_sample_type aif_word;
   srsei_pkg::srsei_sample_type tx_word;

   logic rx_take;
   logic corrupt_now;

   logic invalid_auto;
   logic aif_replace;
   logic tx_replace;
   logic error_fill_select;
   logic pass_flagged_data;

   logic cause_clear;
   logic payload_type_changed;
   logic copy_flag_changed;
   logic rate_code_changed;
   logic lock_state_changed;
   logic emphasis_changed;

   srsei_stream_if #(.W(24)) raw_s ();
   srsei_stream_if #(.W(48)) buf_in_s ();
   srsei_stream_if #(.W(48)) buf_out_s ();

   //----------
   // Configuration registers
   //----------
   // Writes to read-only offsets are dropped
   assign error_fill_select = rx_error_fill_config_q[`SRSEI_FILL_ZERO_BIT];
   assign pass_flagged_data = rx_error_fill_config_q[`SRSEI_PASS_BIT];

   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         rx_error_fill_config_q <= `SRSEI_FILL_RST; // RULE14 RULE15
      end else if (reg_wr_i && reg_addr_i == `SRSEI_ADDR_FILL) begin
         rx_error_fill_config_q <= reg_wdata_i;
      end
   end

   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         irq_suppress_reg_q <= `SRSEI_MASK_RST; // RULE8
      end else if (reg_wr_i && reg_addr_i == `SRSEI_ADDR_MASK) begin
         irq_suppress_reg_q <= reg_wdata_i;
      end
   end

   //----------
   // Status capture
   //----------
   // Status lags the inputs by one cycle
   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         nonlinear_q <= 1'b0;
         copy_permit_flag_q <= 1'b0;
         preemphasis_flag_q <= 1'b0;
         recovered_rate_code_q <= 2'h0;
         unlock_q <= 1'b0;
         cs_refresh_flag_q <= 1'b0;
         burst_sync_q <= 1'b0;
      end else begin
         nonlinear_q <= cs_nonlinear_i; // RULE1
         copy_permit_flag_q <= copy_permit_flag_i; // RULE3
         preemphasis_flag_q <= preemphasis_flag_i; // RULE4
         recovered_rate_code_q <= recovered_rate_code_i; // RULE5
         unlock_q <= unlock_i; // RULE6
         cs_refresh_flag_q <= cs_refresh_flag_i;
         burst_sync_q <= burst_sync; // RULE2
      end
   end

   always_comb begin
      rx_status_reg = 8'h00;
      rx_status_reg[0] = nonlinear_q; // RULE1
      rx_status_reg[1] = burst_sync_q; // RULE2
      rx_status_reg[2] = copy_permit_flag_q; // RULE3
      rx_status_reg[3] = preemphasis_flag_q; // RULE4
      rx_status_reg[5:4] = recovered_rate_code_q; // RULE5
      rx_status_reg[6] = unlock_q; // RULE6
   end

   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         payload_compressed_q <= 1'b0;
      end else begin
         payload_compressed_q <= nonlinear_q | burst_sync_q; // RULE18
      end
   end

   assign payload_compressed_o = payload_compressed_q;

   //----------
   // Burst sync detection
   //----------
   // Detector restarts while unlocked
   assign raw_s.data = rx_sample_i;
   assign raw_s.valid = rx_valid_i;
   assign raw_s.ready = buf_in_s.ready;

   srsei_burst_sync u_sync (
      .mclk_i(mclk_i),
      .rst_i(rst_i),
      .raw_m(raw_s.mon),
      .clr_i(unlock_q),
      .sync_o(burst_sync)
   ); // RULE17

   //----------
   // Subframe error flags
   //----------
   assign rx_take = rx_valid_i & buf_in_s.ready;
   assign corrupt_now = rx_biphase_err_i | rx_parity_err_i | rx_preamble_err_i; // RULE10

   // Flags follow the most recently accepted subframe
   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         rx_frame_corrupt_q <= 1'b0;
         rx_invalid_q <= 1'b0;
      end else if (rx_take) begin
         rx_frame_corrupt_q <= corrupt_now; // RULE10
         rx_invalid_q <= rx_validity_i; // RULE11
      end
   end

   //----------
   // Error substitution
   //----------
   // Automatic handling only where the cause is suppressed
   assign invalid_auto = rx_validity_i & irq_suppress_reg_q[`SRSEI_C_INVALID]
                         & ~pass_flagged_data; // RULE12 RULE15
   assign aif_replace = (corrupt_now & irq_suppress_reg_q[`SRSEI_C_CORRUPT])
                        | invalid_auto; // RULE12 RULE14
   assign tx_replace = invalid_auto; // RULE16

   always_comb begin
      aif_word = rx_sample_i;
      tx_word = rx_sample_i;
      if (aif_replace) begin
         aif_word = error_fill_select ? '0 : last_aif_q; // RULE14
      end
      if (tx_replace) begin
         tx_word = error_fill_select ? '0 : last_tx_q; // RULE14
      end
   end

   // Last good sample per path, for repetition fill
   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         last_aif_q <= '0;
         last_tx_q <= '0;
      end else if (rx_take) begin
         if (!aif_replace) begin
            last_aif_q <= rx_sample_i;
         end
         if (!tx_replace) begin
            last_tx_q <= rx_sample_i;
         end
      end
   end

   //----------
   // Output buffer
   //----------
   // One entry carries both paths, so they stay aligned
   assign buf_in_s.data = {aif_word, tx_word};
   assign buf_in_s.valid = rx_valid_i;
   assign buf_out_s.ready = out_ready_i;
   assign rx_ready_o = buf_in_s.ready;
   assign aif_data_o = buf_out_s.data[47:24];
   assign tx_data_o = buf_out_s.data[23:0];
   assign out_valid_o = buf_out_s.valid;

   srsei_pair_buf u_buf (
      .mclk_i(mclk_i),
      .rst_i(rst_i),
      .in_s(buf_in_s.snk),
      .out_s(buf_out_s.src)
   );

   //----------
   // Interrupt causes
   //----------
   // Masked causes never latch
   assign lock_state_changed = unlock_i ^ unlock_q;
   assign payload_type_changed = (cs_nonlinear_i ^ nonlinear_q)
                                 | (burst_sync ^ burst_sync_q); // RULE19
   assign copy_flag_changed = copy_permit_flag_i ^ copy_permit_flag_q;
   assign emphasis_changed = preemphasis_flag_i ^ preemphasis_flag_q;
   assign rate_code_changed = |(recovered_rate_code_i ^ recovered_rate_code_q); // RULE21

   always_comb begin
      cause_event = 8'h00;
      cause_event[`SRSEI_C_LOCK] = lock_state_changed; // RULE9
      cause_event[`SRSEI_C_INVALID] = rx_invalid_q; // RULE20
      cause_event[`SRSEI_C_CSREF] = cs_refresh_flag_i & ~cs_refresh_flag_q; // RULE21
      cause_event[`SRSEI_C_CORRUPT] = rx_frame_corrupt_q; // RULE20
      cause_event[`SRSEI_C_PAYLOAD] = payload_type_changed; // RULE19
      cause_event[`SRSEI_C_COPY] = copy_flag_changed;
      cause_event[`SRSEI_C_EMPH] = emphasis_changed;
      cause_event[`SRSEI_C_RATE] = rate_code_changed; // RULE9
   end

   assign cause_clear = reg_rd_i && reg_addr_i == `SRSEI_ADDR_CAUSE;

   // A new event in the clearing cycle survives the clear
   always_comb begin
      irq_cause_reg_d = cause_clear ? 8'h00 : irq_cause_reg_q; // RULE22
      irq_cause_reg_d = irq_cause_reg_d | (cause_event & ~irq_suppress_reg_q); // RULE8
   end

   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         irq_cause_reg_q <= 8'h00;
      end else begin
         irq_cause_reg_q <= irq_cause_reg_d; // RULE22
      end
   end

   // Registered so the pin cannot glitch
   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         irq_n_q <= 1'b1;
      end else begin
         irq_n_q <= ~|irq_cause_reg_d; // RULE23
      end
   end

   assign irq_n_o = irq_n_q;

   //----------
   // Register read
   //----------
   // Reading the cause register clears it
   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         rdata_q <= 8'h00;
      end else if (reg_rd_i) begin
         unique case (reg_addr_i)
            `SRSEI_ADDR_FILL: rdata_q <= rx_error_fill_config_q;
            `SRSEI_ADDR_MASK: rdata_q <= irq_suppress_reg_q;
            `SRSEI_ADDR_CAUSE: rdata_q <= irq_cause_reg_q;
            `SRSEI_ADDR_STAT: rdata_q <= rx_status_reg; // RULE7
            default: rdata_q <= 8'h00;
         endcase
      end
   end

   assign reg_rdata_o = rdata_q;

endmodule

// >>> logic/srsei_cfg.svh
// Register offsets, field positions, reset values and counts of the
// receiver status and error block. Assumes an 8-bit register port.
`ifndef SRSEI_CFG_SVH
`define SRSEI_CFG_SVH
`define SRSEI_ADDR_FILL 7'h08
`define SRSEI_ADDR_MASK 7'h0A
`define SRSEI_ADDR_CAUSE 7'h0B
`define SRSEI_ADDR_STAT 7'h0C
`define SRSEI_FILL_RST 8'h00
`define SRSEI_MASK_RST 8'h00
`define SRSEI_FILL_ZERO_BIT 5
`define SRSEI_PASS_BIT 6
`define SRSEI_C_LOCK 0
`define SRSEI_C_INVALID 1
`define SRSEI_C_CSREF 2
`define SRSEI_C_CORRUPT 3
`define SRSEI_C_PAYLOAD 4
`define SRSEI_C_COPY 5
`define SRSEI_C_EMPH 6
`define SRSEI_C_RATE 7
`define SRSEI_SYNC_PA 16'hF872
`define SRSEI_SYNC_PB 16'h4E1F
`define SRSEI_SYNC_HOLD 16'h1800
`endif

// >>> logic/srsei_pkg.sv
// Types shared by the receiver status and error block.
// Assumes a 24-bit received sample word.
package srsei_pkg;
   typedef logic [23:0] srsei_sample_type;
   typedef enum logic [2:0] {
      SYNC_Z0 = 3'b000,
      SYNC_Z1 = 3'b001,
      SYNC_Z2 = 3'b010,
      SYNC_Z3 = 3'b011,
      SYNC_PA = 3'b100,
      SYNC_PB = 3'b101
   } srsei_sync_state_type;
endpackage

// >>> logic/srsei_stream_if.sv
// Word stream with valid and ready between the block's own modules.
// Assumes one clock for both ends.
`timescale 1ns/1ps
interface srsei_stream_if #(parameter int W = 24);
   logic [W-1:0] data;
   logic valid;
   logic ready;
   modport src(output data, output valid, input ready);
   modport snk(input data, input valid, output ready);
   modport mon(input data, input valid, input ready);
endinterface

// >>> logic/srsei_pair_buf.sv
// Two-entry buffer; the head entry drives the output directly.
// Assumes both sides on mclk_i.
`timescale 1ns/1ps
module srsei_pair_buf (
   // Clock and reset
   input wire logic mclk_i,
   input wire logic rst_i,
   // Streams
   srsei_stream_if.snk in_s,
   srsei_stream_if.src out_s
);
   localparam int W = $bits(in_s.data);
   logic [W-1:0] e0_q;
   logic [W-1:0] e1_q;
   logic e0v_q;
   logic e1v_q;
   logic rdy_q;
   logic push;
   logic pop;
   logic e0v_d;
   logic e1v_d;

   assign push = in_s.valid & rdy_q;
   assign pop = e0v_q & out_s.ready;
   assign in_s.ready = rdy_q;
   assign out_s.data = e0_q;
   assign out_s.valid = e0v_q;

   always_comb begin
      e0v_d = e0v_q;
      e1v_d = e1v_q;
      if (pop) begin
         e0v_d = e1v_q | push;
         e1v_d = e1v_q & push;
      end else if (push) begin
         e0v_d = 1'b1;
         e1v_d = e0v_q;
      end
   end

   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         e0v_q <= 1'b0;
         e1v_q <= 1'b0;
         rdy_q <= 1'b1;
      end else begin
         e0v_q <= e0v_d;
         e1v_q <= e1v_d;
         rdy_q <= ~e1v_d;
      end
   end

   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         e0_q <= '0;
         e1_q <= '0;
      end else if (pop) begin
         e0_q <= e1v_q ? e1_q : in_s.data;
         e1_q <= in_s.data;
      end else if (push) begin
         if (e0v_q) begin
            e1_q <= in_s.data;
         end else begin
            e0_q <= in_s.data;
         end
      end
   end
endmodule

// >>> logic/srsei_burst_sync.sv
// Burst sync detector on the received word stream.
// Assumes the upper 16 bits of each accepted word carry the payload word.
`timescale 1ns/1ps
`include "srsei_cfg.svh"
module srsei_burst_sync (
   // Clock and reset
   input wire logic mclk_i,
   input wire logic rst_i,
   // Watched stream and control
   srsei_stream_if.mon raw_m,
   input wire logic clr_i,
   output logic sync_o
);
   srsei_pkg::srsei_sync_state_type state_q;
   srsei_pkg::srsei_sync_state_type state_d;
   logic [15:0] word;
   logic [15:0] gap_q;
   logic take;
   logic zero;
   logic hit;

   assign word = raw_m.data[23:8];
   assign take = raw_m.valid & raw_m.ready;
   assign zero = (word == 16'h0000);

   // Four zero words, then Pa, then Pb
   always_comb begin
      hit = 1'b0;
      unique case (state_q)
         srsei_pkg::SYNC_Z0: state_d = zero ? srsei_pkg::SYNC_Z1 : srsei_pkg::SYNC_Z0;
         srsei_pkg::SYNC_Z1: state_d = zero ? srsei_pkg::SYNC_Z2 : srsei_pkg::SYNC_Z0;
         srsei_pkg::SYNC_Z2: state_d = zero ? srsei_pkg::SYNC_Z3 : srsei_pkg::SYNC_Z0;
         srsei_pkg::SYNC_Z3: state_d = zero ? srsei_pkg::SYNC_PA : srsei_pkg::SYNC_Z0;
         srsei_pkg::SYNC_PA: begin
            if (word == `SRSEI_SYNC_PA) begin
               state_d = srsei_pkg::SYNC_PB;
            end else begin
               state_d = zero ? srsei_pkg::SYNC_PA : srsei_pkg::SYNC_Z0;
            end
         end
         srsei_pkg::SYNC_PB: begin
            hit = (word == `SRSEI_SYNC_PB); // RULE17
            if (hit) begin
               state_d = srsei_pkg::SYNC_Z0;
            end else begin
               state_d = zero ? srsei_pkg::SYNC_Z1 : srsei_pkg::SYNC_Z0;
            end
         end
         default: state_d = srsei_pkg::SYNC_Z0;
      endcase
   end

   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         state_q <= srsei_pkg::SYNC_Z0;
      end else if (clr_i) begin
         state_q <= srsei_pkg::SYNC_Z0;
      end else if (take) begin
         state_q <= state_d;
      end
   end

   // Flag holds while bursts keep arriving within the hold window
   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         sync_o <= 1'b0;
         gap_q <= 16'h0000;
      end else if (clr_i) begin
         sync_o <= 1'b0;
         gap_q <= 16'h0000;
      end else if (take & hit) begin
         sync_o <= 1'b1;
         gap_q <= 16'h0000;
      end else if (take & sync_o) begin
         if (gap_q == `SRSEI_SYNC_HOLD) begin
            sync_o <= 1'b0;
         end else begin
            gap_q <= gap_q + 16'h0001;
         end
      end
   end
endmodule

// >>> dv/srsei_checker.sv
// Port checker for the receiver status, cause and error fill block.
// Assumes one clock and the parallel strobe register port.
`timescale 1ns/1ps
module srsei_checker (
   // Clock and reset
   input wire logic mclk_i,
   input wire logic rst_i,
   // Register port
   input wire logic [6:0] reg_addr_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   input wire logic [7:0] reg_wdata_i,
   input wire logic [7:0] reg_rdata_o,
   // Status inputs
   input wire logic cs_nonlinear_i,
   input wire logic copy_permit_flag_i,
   input wire logic preemphasis_flag_i,
   input wire logic [1:0] recovered_rate_code_i,
   input wire logic unlock_i,
   // Streams and indications
   input wire logic [23:0] rx_sample_i,
   input wire logic rx_valid_i,
   input wire logic rx_ready_o,
   input wire logic rx_biphase_err_i,
   input wire logic rx_parity_err_i,
   input wire logic rx_preamble_err_i,
   input wire logic rx_validity_i,
   input wire logic [23:0] aif_data_o,
   input wire logic [23:0] tx_data_o,
   input wire logic out_valid_o,
   input wire logic irq_n_o
);
   logic [7:0] mask_q, fill_q;
   logic [1:0] age_q;
   logic bad, take_idle, st_rd;
   assign bad = rx_biphase_err_i | rx_parity_err_i | rx_preamble_err_i;
   // Take into an empty buffer
   assign take_idle = rx_valid_i & rx_ready_o & ~out_valid_o;
   assign st_rd = reg_rd_i && reg_addr_i == 7'h0C && age_q == 2'h3;
   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         mask_q <= 8'h00;
         fill_q <= 8'h00;
      end else if (reg_wr_i) begin
         if (reg_addr_i == 7'h0A) mask_q <= reg_wdata_i;
         if (reg_addr_i == 7'h08) fill_q <= reg_wdata_i;
      end
   end
   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         age_q <= 2'h0;
      end else if (age_q != 2'h3) begin
         age_q <= age_q + 2'h1;
      end
   end
   default clocking @(posedge mclk_i); endclocking
   default disable iff (rst_i);
   stat_unlock_a: assert property (
      st_rd && $stable(unlock_i)
      |=> reg_rdata_o[6] == $past(unlock_i)) else $error("status unlock bit wrong");
   stat_rate_a: assert property (
      st_rd && $stable(recovered_rate_code_i)
      |=> reg_rdata_o[5:4] == $past(recovered_rate_code_i)) else $error("status rate wrong");
   stat_flags_a: assert property (
      st_rd && $stable({cs_nonlinear_i, copy_permit_flag_i, preemphasis_flag_i})
      |=> {reg_rdata_o[7], reg_rdata_o[3:2], reg_rdata_o[0]} == {1'b0,
      $past({preemphasis_flag_i, copy_permit_flag_i, cs_nonlinear_i})})
      else $error("status flag bits wrong");
   irq_cause_a: assert property (
      reg_rd_i && reg_addr_i == 7'h0B |=> $past(irq_n_o) == (reg_rdata_o == 8'h00))
      else $error("interrupt level disagrees with causes");
   invalid_level_a: assert property (
      rx_valid_i && rx_ready_o && rx_validity_i && !mask_q[1] |-> ##[1:3] !irq_n_o)
      else $error("invalid sample raised no interrupt");
   corrupt_level_a: assert property (
      rx_valid_i && rx_ready_o && bad && !mask_q[3] |-> ##[1:3] !irq_n_o)
      else $error("corrupt sample raised no interrupt");
   pass_data_a: assert property (
      take_idle && !mask_q[1] && !mask_q[3] |=> aif_data_o == $past(rx_sample_i)
      && tx_data_o == $past(rx_sample_i)) else $error("unmasked data altered");
   zero_fill_a: assert property (
      take_idle && bad && mask_q[3] && fill_q[5] |=> aif_data_o == 24'h000000)
      else $error("zero fill missing");
   tx_keep_a: assert property (
      take_idle && bad && !rx_validity_i |=> tx_data_o == $past(rx_sample_i))
      else $error("corrupt flag altered transmit data");
   pass_flag_a: assert property (
      take_idle && rx_validity_i && !bad && fill_q[6] |=> aif_data_o == $past(rx_sample_i))
      else $error("pass bit did not pass invalid data");
endmodule
bind srsei_top srsei_checker chk (.*);

// >>> dv/srsei_host.sv
// Host model on the register port: one-cycle strobes, negedge driven.
// Assumes the design samples strobes on the rising edge of mclk_i.
`timescale 1ns/1ps
module srsei_host (
   // Clock
   input wire logic mclk_i,
   // Register port
   input wire logic [7:0] reg_rdata_i,
   output logic [6:0] addr_o = 7'h00,
   output logic wr_o = 1'h0,
   output logic rd_o = 1'h0,
   output logic [7:0] wdata_o = 8'h00
);
   task automatic wr(input logic [6:0] a, input logic [7:0] d);
      @(negedge mclk_i);
      addr_o = a;
      wdata_o = d;
      wr_o = 1'h1;
      @(negedge mclk_i);
      wr_o = 1'h0;
   endtask
   // Read data is sampled one cycle after the strobe drops
   task automatic rd(input logic [6:0] a, output logic [23:0] d);
      @(negedge mclk_i);
      addr_o = a;
      rd_o = 1'h1;
      @(negedge mclk_i);
      rd_o = 1'h0;
      @(negedge mclk_i);
      d = {16'h0000, reg_rdata_i};
   endtask
endmodule

// >>> dv/tb_srsei_top.sv
// Bench for the status, cause and fill block.
// Assumes srsei_host and the bound checker.
`timescale 1ns/1ps
module tb_srsei_top;
   logic mclk_i = 1'h0;
   logic rst_i = 1'h1;
   logic [6:0] reg_addr_i;
   logic reg_wr_i, reg_rd_i;
   logic [7:0] reg_wdata_i, reg_rdata_o;
   logic cs_nonlinear_i = 1'h0, copy_permit_flag_i = 1'h0, preemphasis_flag_i = 1'h0;
   logic unlock_i = 1'h0, cs_refresh_flag_i = 1'h0;
   logic [1:0] recovered_rate_code_i = 2'h0;
   logic [23:0] rx_sample_i = 24'h000000, aif_data_o, tx_data_o, rv, ga, gt;
   logic rx_valid_i = 1'h0, rx_ready_o, rx_validity_i = 1'h0;
   logic rx_biphase_err_i = 1'h0, rx_parity_err_i = 1'h0, rx_preamble_err_i = 1'h0;
   logic out_valid_o, out_ready_i = 1'h1, payload_compressed_o, irq_n_o;
   int error_cnt = 0;
   int n_checks = 0;
   always #4 mclk_i = ~mclk_i;
   srsei_top dut (.*);
   srsei_host host (.mclk_i(mclk_i), .reg_rdata_i(reg_rdata_o), .addr_o(reg_addr_i),
      .wr_o(reg_wr_i), .rd_o(reg_rd_i), .wdata_o(reg_wdata_i));
   // ----------
   // Shared tasks
   // ----------
   task automatic chk(input string nm, input logic [23:0] seen, input logic [23:0] exp);
      n_checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("FAIL %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic end_sim();
      $display("Checks %0d mismatches %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   task automatic wait_cyc(input int n);
      repeat (n) @(negedge mclk_i);
   endtask
   task automatic wait_hi(input bit o);
      int i;
      for (i = 0; i < 50 && (o ? out_valid_o : rx_ready_o) !== 1'h1; i++) @(negedge mclk_i);
      if (i == 50) begin
         error_cnt++;
         end_sim();
      end
   endtask
   task automatic push(input logic [23:0] s, input logic [3:0] f);
      @(negedge mclk_i);
      rx_sample_i = s;
      {rx_validity_i, rx_preamble_err_i, rx_parity_err_i, rx_biphase_err_i} = f;
      rx_valid_i = 1'h1;
      wait_hi(1'h0);
      @(negedge mclk_i);
      rx_valid_i = 1'h0;
   endtask
   task automatic pop();
      wait_hi(1'h1);
      ga = aif_data_o;
      gt = tx_data_o;
      @(negedge mclk_i);
   endtask
   task automatic send(input logic [23:0] s, input logic [3:0] f);
      push(s, f);
      pop();
   endtask
   task automatic xfer(input logic [23:0] s, input logic [3:0] f, input logic [23:0] ea,
      input logic [23:0] et);
      send(s, f);
      chk("aif word", ga, ea);
      chk("tx word", gt, et);
   endtask
   task automatic fire(input int n);
      @(negedge mclk_i);
      case (n)
         0: unlock_i = ~unlock_i;
         1, 3: begin
            send(24'h000111, n == 1 ? 4'h8 : 4'h1);
            send(24'h000000, 4'h0);
         end
         2: cs_refresh_flag_i = ~cs_refresh_flag_i;
         4: cs_nonlinear_i = ~cs_nonlinear_i;
         5: copy_permit_flag_i = ~copy_permit_flag_i;
         6: preemphasis_flag_i = ~preemphasis_flag_i;
         default: recovered_rate_code_i = recovered_rate_code_i + 2'h1;
      endcase
      wait_cyc(3);
   endtask
   // ----------
   // Scenarios
   // ----------
   task automatic t_regs();
      host.rd(7'h0A, rv);
      chk("mask reset", rv, 24'h000000);
      host.rd(7'h08, rv);
      chk("fill reset", rv, 24'h000000);
      host.wr(7'h0A, 8'hA5);
      host.rd(7'h0A, rv);
      chk("mask rw", rv, 24'h0000A5);
      host.wr(7'h0C, 8'hFF);
      host.rd(7'h0C, rv);
      chk("status ro", rv, 24'h000000);
      host.rd(7'h3F, rv);
      chk("unmapped", rv, 24'h000000);
   endtask
   task automatic t_status();
      int r;
      {cs_nonlinear_i, copy_permit_flag_i, preemphasis_flag_i, unlock_i} = 4'hF;
      for (r = 0; r < 4; r++) begin
         recovered_rate_code_i = r[1:0];
         wait_cyc(3);
         host.rd(7'h0C, rv);
         chk("status", rv, {16'h0000, 2'h1, r[1:0], 4'hD});
      end
      {cs_nonlinear_i, copy_permit_flag_i, preemphasis_flag_i, unlock_i} = 4'h0;
      recovered_rate_code_i = 2'h0;
      wait_cyc(3);
      host.rd(7'h0C, rv);
      chk("status low", rv, 24'h000000);
   endtask
   task automatic t_causes();
      int n;
      for (n = 0; n < 8; n++) begin
         host.wr(7'h0A, 8'hFF ^ (8'h01 << n));
         host.rd(7'h0B, rv);
         fire(n);
         chk("irq low", {23'h0, irq_n_o}, 24'h000000);
         host.rd(7'h0B, rv);
         chk("cause", rv, {16'h0000, 8'h01 << n});
         chk("irq high", {23'h0, irq_n_o}, 24'h000001);
         host.wr(7'h0A, 8'hFF);
         fire(n);
         host.rd(7'h0B, rv);
         chk("masked", rv, 24'h000000);
      end
   endtask
   task automatic t_level();
      host.wr(7'h0A, 8'hFD);
      host.rd(7'h0B, rv);
      send(24'h000ABC, 4'h8);
      host.rd(7'h0B, rv);
      chk("invalid set", rv, 24'h000002);
      host.rd(7'h0B, rv);
      chk("invalid again", rv, 24'h000002);
      send(24'h000000, 4'h0);
      host.rd(7'h0B, rv);
      host.rd(7'h0B, rv);
      chk("invalid gone", rv, 24'h000000);
      host.wr(7'h0A, 8'hFB);
      host.rd(7'h0B, rv);
      cs_refresh_flag_i = 1'h1;
      wait_cyc(3);
      host.rd(7'h0B, rv);
      chk("refresh rise", rv, 24'h000004);
      host.rd(7'h0B, rv);
      chk("refresh held", rv, 24'h000000);
      cs_refresh_flag_i = 1'h0;
   endtask
   task automatic t_sync();
      host.wr(7'h0A, 8'h00);
      host.rd(7'h0B, rv);
      repeat (4) send(24'h000000, 4'h0);
      send(24'hF87200, 4'h0);
      send(24'h4E1F00, 4'h0);
      wait_cyc(3);
      host.rd(7'h0C, rv);
      chk("sync status", rv, 24'h000022);
      chk("compressed", {23'h0, payload_compressed_o}, 24'h000001);
      host.rd(7'h0B, rv);
      chk("payload cause", rv & 24'h000010, 24'h000010);
   endtask
   task automatic t_fill();
      host.wr(7'h0A, 8'h0A);
      xfer(24'h111111, 4'h0, 24'h111111, 24'h111111);
      xfer(24'h222222, 4'h1, 24'h111111, 24'h222222);
      xfer(24'h333333, 4'h8, 24'h111111, 24'h222222);
      host.wr(7'h08, 8'h20);
      xfer(24'h444444, 4'h8, 24'h000000, 24'h000000);
      host.wr(7'h08, 8'h60);
      xfer(24'h555555, 4'h8, 24'h555555, 24'h555555);
      xfer(24'h666666, 4'h4, 24'h000000, 24'h666666);
      host.wr(7'h0A, 8'h00);
      xfer(24'h777777, 4'h2, 24'h777777, 24'h777777);
   endtask
   task automatic t_buffer();
      out_ready_i = 1'h0;
      push(24'hA0A0A0, 4'h0);
      push(24'hB0B0B0, 4'h0);
      wait_cyc(2);
      chk("buffer full", {23'h0, rx_ready_o}, 24'h000000);
      out_ready_i = 1'h1;
      pop();
      chk("first out", ga, 24'hA0A0A0);
      pop();
      chk("second out", ga, 24'hB0B0B0);
   endtask
   initial begin
      repeat (12) @(negedge mclk_i);
      rst_i = 1'h0;
      wait_cyc(2);
      t_regs();
      t_status();
      t_causes();
      t_level();
      t_sync();
      t_fill();
      t_buffer();
      end_sim();
   end
endmodule
